//--- llf_regs.svh
`ifndef LLF_REGS_SVH
`define LLF_REGS_SVH
// Register byte offsets
`define LLF_CTRL_OFS 8'h00
`define LLF_SECURE_POSITION_OFS 8'h04
`define LLF_STAT_OFS 8'h08
// Control register fields
`define LLF_CTRL_SLEEP_BIT 0
`define LLF_CTRL_FSAFE_BIT 1
`define LLF_CTRL_START_BIT 2
// Secure position reset value and the code that disables the secure move
`define LLF_SECURE_POSITION_RST 11'h400
`define LLF_SECURE_POSITION_OFF 11'h400
// Second referencing motion, in full steps
`define LLF_REF_FWD_FS 16'h000A
// Bus silence before loss is flagged, and the clock rate
`define LLF_LOSS_MS 4460
`define LLF_CLK_HZ 25000000
// Command codes of the shared write frames
`define LLF_CMD_SAFE 8'h04
`define LLF_CMD_HALT 8'h05
`define LLF_CMD_ZERO 8'h06
`define LLF_CMD_DUAL 8'h08
`define LLF_CMD_MOTOR 8'h09
`define LLF_CMD_SOFT 8'h0F
`define LLF_CMD_FUSE 8'h10
`define LLF_CMD_STALL 8'h16
`define LLF_CMD_TUNE 8'h2F
// Service codes carried on diagnostic request frames
`define LLF_SVC_SLEEP 8'h00
`define LLF_SVC_READ_ID 8'hB2
`define LLF_SVC_ASSIGN 8'hB7
`endif

//--- llf_pkg.sv
`default_nettype none
package llf_pkg;
	// Loss sequencer states
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_REF_NEG = 3'b001,
		ST_REF_FWD = 3'b010,
		ST_SECURE = 3'b011,
		ST_END = 3'b100,
		ST_STOP = 3'b101,
		ST_SLEEP = 3'b110
	} llf_state_t;
	// Motion request kinds
	typedef enum logic [2:0] {
		MV_NONE = 3'b000,
		MV_REF_NEG = 3'b001,
		MV_REL_FWD = 3'b010,
		MV_ABS = 3'b011,
		MV_HALT = 3'b100,
		MV_SOFT = 3'b101
	} llf_mv_kind_t;
	// Decoded application and service actions
	typedef enum logic [3:0] {
		ACT_NONE = 4'h0,
		ACT_SAFE = 4'h1,
		ACT_HALT = 4'h2,
		ACT_ZERO = 4'h3,
		ACT_SOFT = 4'h4,
		ACT_DUAL_REF = 4'h5,
		ACT_PROG_MOTION = 4'h6,
		ACT_PROG_FUSE = 4'h7,
		ACT_PROG_STALL = 4'h8,
		ACT_MOVE_TUNE = 4'h9,
		ACT_MOVE_TARGET = 4'hA,
		ACT_MOVE_PAIR = 4'hB,
		ACT_SLEEP_SVC = 4'hC,
		ACT_READ_ID = 4'hD,
		ACT_ASSIGN_ID = 4'hE
	} llf_act_t;
	// Response chosen for a read header
	typedef enum logic [2:0] {
		RSP_NONE = 3'b000,
		RSP_POS = 3'b001,
		RSP_FULL = 3'b010,
		RSP_FUSE = 3'b011,
		RSP_SHORT = 3'b100,
		RSP_BEMF = 3'b101,
		RSP_DIAG = 3'b110
	} llf_resp_t;
	// Frame classes from the frame receiver
	typedef enum logic [1:0] {
		FR_WRITE = 2'b00,
		FR_READ = 2'b01,
		FR_DIAG_REQ = 2'b10,
		FR_DIAG_RESP = 2'b11
	} llf_fr_kind_t;
	typedef struct packed {
		logic valid;
		llf_fr_kind_t kind;
		logic [3:0] index;
		logic [7:0] cmd;
	} llf_frame_t;
	typedef struct packed {
		logic done;
		logic stall;
	} llf_motion_t;
	typedef struct packed {
		logic start;
		llf_mv_kind_t kind;
		logic [15:0] target;
		logic use_otp;
	} llf_move_t;
	// Whole state of the block
	typedef struct packed {
		logic lin_s1;
		logic lin_s2;
		logic lin_p;
		logic hw_s1;
		logic hw_s2;
		logic [26:0] timer;
		logic lost;
		logic lstart;
		logic cstrap;
		logic refd;
		logic dpend;
		llf_state_t st;
		logic sleep_en;
		logic fsafe;
		logic start_done;
		logic [10:0] secure_position;
		logic wr;
		logic [7:0] waddr;
		logic [31:0] rdata;
		llf_move_t mv;
		logic pos_clr;
		llf_act_t act;
		logic act_vld;
		llf_resp_t resp;
	} llf_state_vec_t;
endpackage : llf_pkg
`default_nettype wire

//--- llf_failsafe.sv
// Contract
// RULE1 - Start-up loss referencing first moves negative up to half range, fuse-memory parameters.
// RULE2 - At the end stop, clear actual position, then move 10 full steps forward.
// RULE3 - Start-up loss from bus timeout puts the device to sleep.
// RULE4 - Start-up loss with strap floating and fail-safe set: reference, then secure move.
// RULE5 - Otherwise no motion at start-up; start-up loss handling always ends stopped. The code goes straight to sleep when the strap is not floating.
// RULE6 - Normal loss when referenced: absolute move to the stored secure position.
// RULE7 - Normal loss, unreferenced, fail-safe set: two-stage referencing with RAM parameters.
// RULE8 - After the second referencing motion, move to the RAM secure position.
// RULE9 - Skip referencing when already referenced or fail-safe is clear.
// RULE10 - Secure move only when secure position differs from 0x400; copied to target.
// RULE11 - Normal loss handling ends asleep if sleep enable set, else stopped.
// RULE12 - Secure position is 11 bits, one unit per two full steps.
// RULE13 - A floating strap never causes sleep while the bus is active.
// RULE14 - Short frame codes 0x04 secure move, 0x05 halt, 0x06 zero position.
// RULE15 - Short frame code 0x0F stops with deceleration.
// RULE16 - Long frame code 0x08 two-stage move, 0x2F move and tune.
// RULE17 - Long frame 0x09 motion settings, 0x10 fuse byte, 0x16 stall detection.
// RULE18 - Single move on indexes 3 or 4, two-axis move on index 5.
// RULE19 - Read indexes 6 to 10 return position, full status, fuse, short status, back-EMF.
// RULE20 - Sleep service on 0x3C sleeps if sleep enable set, else stops.
// RULE21 - Identification prepared on 0x3C, returned on 0x7D.
// RULE22 - Identifier assignment written on 0x3C, verified by reading 0x7D.
// RULE23 - Loss flag sets after 4.46 s of bus inactivity.
// RULE24 - Sleep enable defaults to disabled.
// RULE25 - Loss records start-up or normal phase and branches on that record.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "llf_regs.svh"
module llf_failsafe
	import llf_pkg::*;
#(
	parameter logic [26:0] LOSS_CYCLES = 27'(`LLF_LOSS_MS * (`LLF_CLK_HZ / 1000)),
	parameter logic [15:0] HALF_RANGE = 16'h0800
) (
	input wire logic clk, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write strobe
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic lin_rx_pin, // Bus receive level
	input wire logic second_address_strap_pin, // High when strap floats
	input wire llf_frame_t frame, // Received frame event
	input wire llf_motion_t motion, // Motion controller status
	output var llf_move_t move, // Motion request
	output logic pos_clear, // Zero the actual position
	output logic sleep_req, // Sleep state
	output logic stopped, // Stop state
	output var llf_act_t act_code, // Decoded action
	output logic act_valid, // Action strobe
	output var llf_resp_t resp_sel // Response to send
);

	// Line stages start at the recessive level, so release shows no false edge
	localparam llf_state_vec_t RST_VAL = '{ // RULE24
		secure_position: `LLF_SECURE_POSITION_RST, lin_s1: 1'b1, lin_s2: 1'b1, lin_p: 1'b1,
		st: ST_RUN, mv: '{kind: MV_NONE, default: '0}, act: ACT_NONE, resp: RSP_NONE,
		default: '0};

	llf_state_vec_t q;
	llf_state_vec_t d;
	logic activity;
	logic accept;
	llf_act_t a;

	// Secure move request, suppressed by the disable code
	function automatic llf_move_t safe_move(input logic [10:0] sp, input logic otp);
		llf_move_t m;
		m.start = (sp != `LLF_SECURE_POSITION_OFF); // RULE10
		m.kind = MV_ABS;
		m.target = {4'h0, sp, 1'b0}; // RULE12
		m.use_otp = otp;
		return m;
	endfunction : safe_move

	// Next state of the whole block
	always_comb begin
		d = q;
		a = ACT_NONE;
		d.lin_s1 = lin_rx_pin;
		d.lin_s2 = q.lin_s1;
		d.lin_p = q.lin_s2;
		d.hw_s1 = second_address_strap_pin;
		d.hw_s2 = q.hw_s1;
		d.mv.start = 1'b0;
		d.pos_clr = 1'b0;
		d.act_vld = 1'b0;
		d.resp = RSP_NONE;
		activity = (q.lin_s2 != q.lin_p) | frame.valid;
		accept = hsel & htrans[1] & hready & (hsize == 3'b010);

		// Any edge or frame restarts the silence timer
		if (activity) begin
			d.timer = 27'h0;
			d.lost = 1'b0;
		end else if (q.timer >= LOSS_CYCLES) begin
			d.lost = 1'b1; // RULE23
		end else begin
			d.timer = q.timer + 27'h1;
		end

		// Register writes land in the data phase
		d.wr = accept & hwrite;
		d.waddr = haddr[7:0];
		if (q.wr) begin
			case (q.waddr)
				`LLF_CTRL_OFS: begin
					d.sleep_en = hwdata[`LLF_CTRL_SLEEP_BIT];
					d.fsafe = hwdata[`LLF_CTRL_FSAFE_BIT];
					d.start_done = hwdata[`LLF_CTRL_START_BIT];
				end
				`LLF_SECURE_POSITION_OFS: d.secure_position = hwdata[10:0]; // RULE12
				default: d.secure_position = d.secure_position;
			endcase
		end

		// Loss sequencer
		case (q.st)
			ST_RUN: begin
				// Loss only exists after silence, so a floating strap alone never sleeps
				if (q.lost) begin // RULE13
					d.lstart = ~q.start_done; // RULE25
					d.cstrap = q.hw_s2;
					if (~q.start_done) begin
						if (~q.hw_s2) begin
							d.st = ST_SLEEP; // RULE3
						end else if (q.fsafe) begin
							d.mv = '{1'b1, MV_REF_NEG, HALF_RANGE, 1'b1}; // RULE1 RULE4
							d.st = ST_REF_NEG;
						end else begin
							d.st = ST_END; // RULE5
						end
					end else if (~q.refd & q.fsafe) begin
						d.mv = '{1'b1, MV_REF_NEG, HALF_RANGE, 1'b0}; // RULE7
						d.st = ST_REF_NEG;
					end else begin
						d.mv = safe_move(q.secure_position, 1'b0); // RULE6 RULE9
						d.st = d.mv.start ? ST_SECURE : ST_END;
					end
				end
			end
			ST_REF_NEG: begin
				// End stop reached: zero the position, then step clear of it
				if (motion.done | motion.stall) begin
					d.pos_clr = 1'b1; // RULE2
					d.mv = '{1'b1, MV_REL_FWD, `LLF_REF_FWD_FS, q.lstart}; // RULE2
					d.st = ST_REF_FWD;
				end
			end
			ST_REF_FWD: begin
				if (motion.done) begin
					d.refd = 1'b1;
					d.mv = safe_move(q.secure_position, q.lstart); // RULE8 RULE4
					d.st = d.mv.start ? ST_SECURE : ST_END;
				end
			end
			ST_SECURE: begin
				if (motion.done) begin
					d.st = ST_END;
				end
			end
			ST_END: begin
				// Start-up handling always stops; normal handling honours sleep enable
				d.st = (~q.lstart & q.sleep_en) ? ST_SLEEP : ST_STOP; // RULE5 RULE11
			end
			ST_STOP, ST_SLEEP: begin
				if (activity) begin
					d.st = ST_RUN;
				end
			end
			default: d.st = ST_RUN;
		endcase

		// Frame decode; motion commands take the motor back from the sequencer
		if (frame.valid) begin
			case (frame.kind)
				FR_WRITE: begin
					case (frame.index)
						4'h0: begin
							case (frame.cmd)
								`LLF_CMD_DUAL: a = ACT_DUAL_REF; // RULE16
								`LLF_CMD_TUNE: a = ACT_MOVE_TUNE; // RULE16
								`LLF_CMD_MOTOR: a = ACT_PROG_MOTION; // RULE17
								`LLF_CMD_FUSE: a = ACT_PROG_FUSE; // RULE17
								`LLF_CMD_STALL: a = ACT_PROG_STALL; // RULE17
								default: a = ACT_NONE;
							endcase
							if (a == ACT_DUAL_REF) begin
								d.refd = 1'b1;
							end
						end
						4'h1, 4'h2: begin
							case (frame.cmd)
								`LLF_CMD_SAFE: begin
									a = ACT_SAFE; // RULE14
									d.mv = safe_move(q.secure_position, 1'b0);
								end
								`LLF_CMD_HALT: begin
									a = ACT_HALT; // RULE14
									d.mv = '{1'b1, MV_HALT, q.mv.target, 1'b0};
								end
								`LLF_CMD_ZERO: begin
									a = ACT_ZERO; // RULE14
									d.pos_clr = 1'b1;
									d.refd = 1'b1;
								end
								`LLF_CMD_SOFT: begin
									a = ACT_SOFT; // RULE15
									d.mv = '{1'b1, MV_SOFT, q.mv.target, 1'b0};
								end
								default: a = ACT_NONE;
							endcase
						end
						4'h3, 4'h4: a = ACT_MOVE_TARGET; // RULE18
						4'h5: a = ACT_MOVE_PAIR; // RULE18
						default: a = ACT_NONE;
					endcase
					if (a != ACT_NONE) begin
						d.st = ST_RUN;
					end
				end
				FR_READ: begin
					case (frame.index)
						4'h6: d.resp = RSP_POS; // RULE19
						4'h7: d.resp = RSP_FULL; // RULE19
						4'h8: d.resp = RSP_FUSE; // RULE19
						4'h9: d.resp = RSP_SHORT; // RULE19
						4'hA: d.resp = RSP_BEMF; // RULE19
						default: d.resp = RSP_NONE;
					endcase
				end
				FR_DIAG_REQ: begin
					case (frame.cmd)
						`LLF_SVC_SLEEP: begin
							a = ACT_SLEEP_SVC;
							d.st = q.sleep_en ? ST_SLEEP : ST_STOP; // RULE20
						end
						`LLF_SVC_READ_ID: begin
							a = ACT_READ_ID; // RULE21
							d.dpend = 1'b1;
						end
						`LLF_SVC_ASSIGN: begin
							a = ACT_ASSIGN_ID; // RULE22
							d.dpend = 1'b1;
						end
						default: a = ACT_NONE;
					endcase
				end
				default: begin
					// A response slot is answered only after a matching request
					if (q.dpend) begin
						d.resp = RSP_DIAG; // RULE21 RULE22
						d.dpend = 1'b0;
					end
				end
			endcase
		end
		d.act_vld = (a != ACT_NONE);
		if (a != ACT_NONE) begin
			d.act = a;
		end

		// Control and secure position reads take the next state so a write just before is seen; status uses the current state
		if (accept & ~hwrite) begin
			case (haddr[7:0])
				`LLF_CTRL_OFS: d.rdata = {29'h0, d.start_done, d.fsafe, d.sleep_en};
				`LLF_SECURE_POSITION_OFS: d.rdata = {21'h0, d.secure_position};
				`LLF_STAT_OFS: d.rdata = {24'h0, q.dpend, q.refd, q.cstrap, q.lstart, q.lost, q.st};
				default: d.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= RST_VAL;
		end else begin
			q <= d;
		end
	end

	// Outputs; the slave never inserts wait states
	assign hrdata = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign move = q.mv;
	assign pos_clear = q.pos_clr;
	assign sleep_req = (q.st == ST_SLEEP);
	assign stopped = (q.st == ST_STOP);
	assign act_code = q.act;
	assign act_valid = q.act_vld;
	assign resp_sel = q.resp;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_startup_loss;
		q.st == ST_RUN && q.lost && !q.start_done && !frame.valid;
	endsequence

	sequence s_normal_end;
		q.st == ST_END && !q.lstart && !frame.valid;
	endsequence

	sequence s_normal_loss;
		q.st == ST_RUN && q.lost && q.start_done && !frame.valid;
	endsequence

	sequence s_short_write;
		frame.valid && frame.kind == FR_WRITE && (frame.index == 4'h1 || frame.index == 4'h2);
	endsequence

	AST_START_REF: assert property (s_startup_loss ##0 (q.hw_s2 && q.fsafe) |=> // RULE1
		q.st == ST_REF_NEG && move.start && move.kind == MV_REF_NEG && move.use_otp)
		else $error("start-up referencing not started");
	AST_START_SLEEP: assert property (s_startup_loss ##0 !q.hw_s2 |=> sleep_req) // RULE3
		else $error("start-up timeout did not sleep");
	AST_ZERO_FWD: assert property (q.st == ST_REF_NEG && (motion.done || motion.stall) // RULE2
		&& !frame.valid |=> pos_clear && move.start && move.kind == MV_REL_FWD
		&& move.target == `LLF_REF_FWD_FS ##1 !pos_clear)
		else $error("end stop handling wrong");
	AST_START_END: assert property (q.st == ST_END && q.lstart && !frame.valid |=> stopped) // RULE5
		else $error("start-up handling did not stop");
	AST_END_SLEEP: assert property (s_normal_end ##0 q.sleep_en |=> sleep_req) // RULE11
		else $error("normal loss did not sleep");
	AST_SECURE_TGT: assert property (move.start && move.kind == MV_ABS |-> // RULE10
		move.target[11:1] == $past(q.secure_position)
		&& $past(q.secure_position) != `LLF_SECURE_POSITION_OFF)
		else $error("secure target wrong");
	AST_HALT_CMD: assert property (frame.valid && frame.kind == FR_WRITE // RULE14
		&& (frame.index == 4'h1 || frame.index == 4'h2) && frame.cmd == `LLF_CMD_HALT
		|=> act_valid && act_code == ACT_HALT && move.start && move.kind == MV_HALT)
		else $error("halt command not decoded");
	AST_READ_POS: assert property (frame.valid && frame.kind == FR_READ // RULE19
		&& frame.index == 4'h6 |=> resp_sel == RSP_POS)
		else $error("position read not selected");
	AST_LOSS_TIME: assert property ($rose(q.lost) |-> q.timer == LOSS_CYCLES // RULE23
		&& $past(q.timer) == LOSS_CYCLES)
		else $error("loss flag timing wrong");
	AST_SLEEP_SVC: assert property (frame.valid && frame.kind == FR_DIAG_REQ // RULE20
		&& frame.cmd == `LLF_SVC_SLEEP |=> sleep_req == $past(q.sleep_en)
		&& stopped == !$past(q.sleep_en))
		else $error("sleep service wrong");
	// Normal loss without a reference runs the stall search on RAM parameters
	AST_NORM_REF: assert property (s_normal_loss ##0 (!q.refd && q.fsafe) |=> // RULE7
		q.st == ST_REF_NEG && move.start && move.kind == MV_REF_NEG && !move.use_otp)
		else $error("normal referencing not started");
	AST_NORM_SKIP: assert property (s_normal_loss ##0 (q.refd || !q.fsafe) |=> // RULE9
		q.st != ST_REF_NEG && !(move.start && move.kind == MV_REF_NEG))
		else $error("referencing not skipped");
	AST_SECURE_OFF: assert property (s_normal_loss ##0 (q.refd || !q.fsafe) // RULE10
		##0 q.secure_position == `LLF_SECURE_POSITION_OFF |=> !move.start && q.st == ST_END)
		else $error("disabled secure move was made");
	AST_REF_THIRD: assert property (q.st == ST_REF_FWD && motion.done // RULE8
		&& !frame.valid |=> q.refd && move.kind == MV_ABS
		&& move.target[11:1] == $past(q.secure_position)
		&& move.start == ($past(q.secure_position) != `LLF_SECURE_POSITION_OFF))
		else $error("third motion wrong");
	// A floating strap alone must never put a talking node to sleep
	AST_STRAP_AWAKE: assert property (q.st == ST_RUN && !q.lost // RULE13
		&& !(frame.valid && frame.kind == FR_DIAG_REQ) |=> !sleep_req)
		else $error("slept without loss");
	AST_ZERO_CMD: assert property (s_short_write ##0 frame.cmd == `LLF_CMD_ZERO // RULE14
		|=> pos_clear && act_valid && act_code == ACT_ZERO && q.refd)
		else $error("zero command not decoded");
	AST_SOFT_CMD: assert property (s_short_write ##0 frame.cmd == `LLF_CMD_SOFT // RULE15
		|=> act_valid && act_code == ACT_SOFT && move.start && move.kind == MV_SOFT)
		else $error("soft stop not decoded");
	AST_DUAL_CMD: assert property (frame.valid && frame.kind == FR_WRITE // RULE16
		&& frame.index == 4'h0 && frame.cmd == `LLF_CMD_DUAL
		|=> act_valid && act_code == ACT_DUAL_REF && q.refd)
		else $error("dual reference not decoded");
	AST_MOVE_IDX: assert property (frame.valid && frame.kind == FR_WRITE // RULE18
		&& (frame.index == 4'h3 || frame.index == 4'h4)
		|=> act_valid && act_code == ACT_MOVE_TARGET)
		else $error("single move not decoded");
	AST_DIAG_RESP: assert property (frame.valid && frame.kind == FR_DIAG_RESP // RULE21 RULE22
		&& q.dpend |=> resp_sel == RSP_DIAG && !q.dpend)
		else $error("diagnostic response missing");

endmodule : llf_failsafe
`default_nettype wire

//--- llf_lin_master.sv
`timescale 1ns/1ps
`default_nettype none
module llf_lin_master
	import llf_pkg::*;
(
	input wire logic clk, // System clock
	output var llf_frame_t frame, // Frame event to the block
	output logic lin_rx_pin // Bus level, recessive high
);
	// Idle bus rests recessive through its pull-up
	initial begin
		frame = '0;
		lin_rx_pin = 1'b1;
	end
	// One frame: a dominant break cycle with a one-cycle frame event
	task automatic send(input llf_fr_kind_t k, input logic [3:0] i, input logic [7:0] c);
		@(posedge clk);
		lin_rx_pin <= 1'b0;
		frame <= '{valid: 1'b1, kind: k, index: i, cmd: c};
		@(posedge clk);
		lin_rx_pin <= 1'b1;
		// Released fields show the inverse, so a stale code never looks fresh
		frame <= '{valid: 1'b0, kind: llf_fr_kind_t'(~k), index: ~i, cmd: ~c};
	endtask : send
endmodule : llf_lin_master
`default_nettype wire

//--- lin_loss_failsafe_and_command_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "llf_regs.svh"
module lin_loss_failsafe_and_command_decode_tb;
	import llf_pkg::*;
	localparam int LC = 200;
	localparam llf_motion_t DONE = 2'h2;
	localparam llf_motion_t STALL = 2'h1;
	logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, strap = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, lin_rx, pos_clear, sleep_req, stopped, act_valid;
	llf_frame_t frm;
	llf_motion_t motion = '0;
	llf_move_t move;
	llf_act_t act_code;
	llf_resp_t resp_sel;
	int fails = 0, total_checks = 0;
	// Frame kind, index, code, expected action, expected move kind (F = none checked)
	logic [23:0] tbl [14] = '{24'h01041F, 24'h010524, 24'h02063F, 24'h020F45, 24'h00085F,
		24'h00096F, 24'h00107F, 24'h00168F, 24'h002F9F, 24'h0300AF, 24'h0400AF, 24'h0500BF,
		24'h20B2DF, 24'h20B7EF};
	// Free-running 25 MHz clock
	always #20 clk = ~clk;
	llf_lin_master u_lin (.clk(clk), .frame(frm), .lin_rx_pin(lin_rx));
	// Short silence limit keeps each loss scenario to a few hundred cycles
	llf_failsafe #(.LOSS_CYCLES(27'(LC))) u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.lin_rx_pin(lin_rx), .second_address_strap_pin(strap), .frame(frm), .motion(motion),
		.move(move), .pos_clear(pos_clear), .sleep_req(sleep_req), .stopped(stopped),
		.act_code(act_code), .act_valid(act_valid), .resp_sel(resp_sel));
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask : chk
	// A wait that used up its bound ends the run
	task automatic wt(input int i);
		if (i >= LC + 50) begin
			$display("mismatch wait expected event seen timeout");
			fails++;
			conclude();
		end
	endtask : wt
	task automatic rdy();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < LC + 50);
		wt(i);
	endtask : rdy
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, '0, q);
		chk(n, e, q);
	endtask : rd
	task automatic rst();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
	endtask : rst
	task automatic pulse(input llf_motion_t m);
		@(posedge clk);
		motion <= m;
		@(posedge clk);
		motion <= '0;
	endtask : pulse
	// Next motion request, checked for kind and target
	task automatic wmove(input llf_mv_kind_t k, input logic [15:0] t);
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (move.start !== 1'b1 && i < LC + 50);
		wt(i);
		chk("move kind", 32'(k), 32'(move.kind));
		chk("move target", 32'(t), 32'(move.target));
	endtask : wmove
	// Final state of loss handling, with no motion on the way
	task automatic wfin(input logic sl);
		int i, m;
		i = 0;
		m = 0;
		do begin
			@(negedge clk);
			i++;
			if (move.start === 1'b1) begin
				m++;
			end
		end while (stopped !== 1'b1 && sleep_req !== 1'b1 && i < LC + 50);
		wt(i);
		chk("moves", 0, m);
		chk("sleep", 32'(sl), 32'(sleep_req));
		chk("stopped", 32'(!sl), 32'(stopped));
	endtask : wfin
	// Referencing run: end stop, forward nudge, secure move, final state
	task automatic refseq(input logic [31:0] c, input logic [10:0] sp, input logic otp,
		input llf_motion_t hit, input logic sl);
		rst();
		wr(32'(`LLF_CTRL_OFS), c);
		wr(32'(`LLF_SECURE_POSITION_OFS), 32'(sp));
		wmove(MV_REF_NEG, 16'h0800);
		chk("fuse params", 32'(otp), 32'(move.use_otp));
		pulse(hit);
		wmove(MV_REL_FWD, `LLF_REF_FWD_FS);
		chk("pos clear", 1, 32'(pos_clear));
		pulse(DONE);
		wmove(MV_ABS, {4'h0, sp, 1'b0});
		pulse(DONE);
		wfin(sl);
	endtask : refseq
	initial begin
		int n;
		rst();
		rd("ctrl", 32'(`LLF_CTRL_OFS), 32'h0);
		rd("secure position", 32'(`LLF_SECURE_POSITION_OFS), 32'h400);
		wr(32'(`LLF_SECURE_POSITION_OFS), 32'hFFFFFFFF);
		rd("secure position width", 32'(`LLF_SECURE_POSITION_OFS), 32'h7FF);
		rd("unmapped", 32'h40, 32'h0);
		chk("hresp", 0, 32'(hresp));
		$display("test registers done");
		for (int j = 0; j < 14; j++) begin
			u_lin.send(llf_fr_kind_t'(tbl[j][21:20]), tbl[j][19:16], tbl[j][15:8]);
			@(negedge clk);
			chk("act", 32'(tbl[j][7:4]), 32'(act_code));
			chk("act valid", 1, 32'(act_valid));
			if (tbl[j][3:0] != 4'hF) begin
				chk("stop kind", 32'(tbl[j][3:0]), 32'(move.kind));
			end
			if (tbl[j][21:20] == 2'h2) begin
				u_lin.send(FR_DIAG_RESP, 4'h0, 8'h00);
				@(negedge clk);
				chk("diag resp", 32'(RSP_DIAG), 32'(resp_sel));
			end
		end
		for (int j = 6; j <= 10; j++) begin
			u_lin.send(FR_READ, 4'(j), 8'h00);
			@(negedge clk);
			chk("resp", 32'(j - 5), 32'(resp_sel));
		end
		for (int s = 1; s >= 0; s--) begin
			wr(32'(`LLF_CTRL_OFS), 32'(s));
			u_lin.send(FR_DIAG_REQ, 4'h0, `LLF_SVC_SLEEP);
			@(negedge clk);
			chk("svc sleep", 32'(s), 32'(sleep_req));
			chk("svc stop", 32'(s == 0), 32'(stopped));
		end
		$display("test decode done");
		rst();
		u_lin.send(FR_READ, 4'h9, 8'h00);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sleep_req !== 1'b1 && n < LC + 50);
		wt(n);
		// Silence counts from the last line edge, through two sync stages and the edge detect
		chk("loss time", 1, 32'(n >= LC + 4 && n <= LC + 8));
		chk("startup sleep", 1, 32'(sleep_req));
		rd("status", 32'(`LLF_STAT_OFS), 32'h1E);
		$display("test startup timeout done");
		strap <= 1'b1;
		rst();
		wr(32'(`LLF_CTRL_OFS), 32'h1);
		repeat (4) begin
			repeat (150) @(posedge clk);
			@(negedge clk);
			chk("strap no sleep", 0, 32'(sleep_req | stopped));
			u_lin.send(FR_READ, 4'h9, 8'h00);
		end
		wfin(1'b0);
		$display("test startup no motion done");
		refseq(32'h3, 11'h123, 1'b1, STALL, 1'b0);
		$display("test startup referencing done");
		refseq(32'h7, 11'h055, 1'b0, DONE, 1'b1);
		$display("test normal referencing done");
		rst();
		wr(32'(`LLF_CTRL_OFS), 32'h6);
		wr(32'(`LLF_SECURE_POSITION_OFS), 32'h200);
		u_lin.send(FR_WRITE, 4'h1, `LLF_CMD_ZERO);
		wmove(MV_ABS, {4'h0, 11'h200, 1'b0});
		pulse(DONE);
		wfin(1'b0);
		rst();
		wr(32'(`LLF_CTRL_OFS), 32'h4);
		wfin(1'b0);
		$display("test normal secure move done");
		conclude();
	end
endmodule : lin_loss_failsafe_and_command_decode_tb
`default_nettype wire
